// *** rtl/wdr_pkg.sv ***
package wdr_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_PS = 4000;
   localparam int US_PS = 1000000;
   localparam int US_CYCLES = US_PS / CLK_PERIOD_PS;
   localparam int PRE_W = 16;
   localparam int CNT_W = 23;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SERVICE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h10;

   // Control field positions and reset value
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_NORMAL_BIT = 2;
   localparam int CTRL_PSEL_LSB = 3;
   localparam int CTRL_RLS_LSB = 6;
   localparam int CTRL_W = 8;
   localparam logic [7:0] CTRL_RST = 8'h05;

   // Status bit positions, mask reset value
   localparam int ST_EARLY = 0;
   localparam int ST_OVF = 1;
   localparam int ST_UV = 2;
   localparam int ST_RST_ACT = 3;
   localparam int ST_UV_LVL = 4;
   localparam int EVT_W = 3;
   localparam logic [2:0] MASK_RST = 3'h0;

   // Watchdog operation modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_TIMEOUT = 2'h1;
   localparam logic [1:0] MODE_WINDOW = 2'h2;

   // Undervoltage timing in microseconds
   localparam int UV_DLY_MIN_US = 6;
   localparam int UV_DLY_MAX_US = 39;
   localparam int UV_RST_MAX_US = 48;
   localparam logic [5:0] UV_DLY_US = 6'h14;

   // Nominal periods in microseconds, 8 ms up to 4 s
   localparam logic [CNT_W-1:0] PERIOD_US [8] = '{
      23'h001F40, 23'h003E80, 23'h007D00, 23'h00FA00,
      23'h01F400, 23'h03E800, 23'h0FA000, 23'h3D0900};

   // Reset pulse lengths in microseconds, inside each band
   localparam logic [CNT_W-1:0] RST_LEN_US [4] = '{
      23'h0057E4, 23'h002BF2, 23'h0010CC, 23'h0004E2};

   // Late limit: the nominal period itself
   function automatic logic [CNT_W-1:0] late_us(input logic [2:0] sel);
      late_us = PERIOD_US[sel];
   endfunction

   // Early limit: half the nominal period
   function automatic logic [CNT_W-1:0] early_us(input logic [2:0] sel);
      early_us = PERIOD_US[sel] >> 1;
   endfunction

endpackage

// *** rtl/wdr_pulse.sv ***
`timescale 1ns/1ps
module wdr_pulse (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Timing
   input wire logic us_tick,
   input wire logic trigger,
   input wire logic [1:0] len_sel,
   // Pulse state
   output logic active
);
   import wdr_pkg::*;

   logic [CNT_W-1:0] left_ff;
   logic active_ff;
   logic [CNT_W-1:0] held_ff;
   logic [CNT_W-1:0] len_ff;

   assign active = active_ff;

   // Load on trigger, count down microseconds, retrigger extends
   always_ff @(posedge clock) begin
      if (!nrst) begin
         left_ff <= '0;
         active_ff <= 1'b0;
      end else if (trigger) begin
         left_ff <= RST_LEN_US[len_sel];
         active_ff <= 1'b1;
      end else if (active_ff && us_tick) begin
         left_ff <= left_ff - CNT_W'(1);
         if (left_ff == CNT_W'(1)) begin
            active_ff <= 1'b0;
         end
      end
   end

   // Helper: ticks seen and length latched for the pulse check
   always_ff @(posedge clock) begin
      if (!nrst) begin
         held_ff <= '0;
         len_ff <= '0;
      end else if (trigger) begin
         held_ff <= '0;
         len_ff <= RST_LEN_US[len_sel];
      end else if (active_ff && us_tick) begin
         held_ff <= held_ff + CNT_W'(1);
      end
   end

   pulse_len_a: assert property (
      @(posedge clock) disable iff (!nrst)
      $fell(active_ff) |-> held_ff == len_ff)
      else $error("reset pulse length differs from selection");

   pulse_start_a: assert property (
      @(posedge clock) disable iff (!nrst)
      trigger |=> active_ff && left_ff == len_ff)
      else $error("reset pulse did not start on trigger");

endmodule

// *** rtl/wdr_top.sv ***
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module wdr_top #(
   parameter int US_TICK_CYCLES = wdr_pkg::US_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Regulator monitor
   input wire logic regulator_output_uv,
   // System outputs
   output logic system_reset_out_n,
   output logic irq
);
   import wdr_pkg::*;

   // Bus pipeline
   logic ap_valid_ff;
   logic ap_write_ff;
   logic [7:0] ap_addr_ff;
   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic hresp_ff;
   logic [31:0] nxt_rdata;
   logic addr_take;
   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;
   logic svc_wr;

   // Registers and block state
   logic [CTRL_W-1:0] ctrl_ff;
   logic [EVT_W-1:0] status_ff;
   logic [EVT_W-1:0] mask_ff;
   logic [EVT_W-1:0] nxt_status;
   logic [CNT_W-1:0] wd_cnt_ff;
   logic [PRE_W-1:0] pre_ff;
   logic us_tick_ff;
   logic [5:0] uv_us_ff;
   logic uv_qual_ff;
   logic rst_active;
   logic rst_out_n_ff;
   logic irq_ff;

   // Decoded control fields
   logic [1:0] wd_mode;
   logic op_normal;
   logic [2:0] period_sel;
   logic [1:0] len_sel;
   logic wd_en;
   logic win_check;
   logic [CNT_W-1:0] early_lim;
   logic [CNT_W-1:0] late_lim;

   // Events
   logic svc_take;
   logic early_evt;
   logic svc_ok;
   logic ovf_evt;
   logic uv_evt;
   logic rst_trig;

   assign hreadyout = hreadyout_ff;
   assign hrdata = hrdata_ff;
   assign hresp = hresp_ff;
   assign system_reset_out_n = rst_out_n_ff;
   assign irq = irq_ff;

   // Field decode; reserved mode code acts as off
   assign wd_mode = ctrl_ff[CTRL_MODE_LSB +: 2];
   assign op_normal = ctrl_ff[CTRL_NORMAL_BIT];
   assign period_sel = ctrl_ff[CTRL_PSEL_LSB +: 3];
   assign len_sel = ctrl_ff[CTRL_RLS_LSB +: 2];
   assign wd_en = (wd_mode == MODE_TIMEOUT) || (wd_mode == MODE_WINDOW);
   assign win_check = (wd_mode == MODE_WINDOW) && op_normal;
   assign early_lim = early_us(period_sel);
   assign late_lim = late_us(period_sel);

   // Address phase is taken when selected, active and bus ready
   assign addr_take = hsel && htrans[1] && hready;

   // Data-phase write strobes
   assign wr_ctrl = ap_valid_ff && ap_write_ff && ap_addr_ff == OFS_CTRL;
   assign wr_status = ap_valid_ff && ap_write_ff &&
                      ap_addr_ff == OFS_STATUS;
   assign wr_mask = ap_valid_ff && ap_write_ff && ap_addr_ff == OFS_MASK;
   assign svc_wr = ap_valid_ff && ap_write_ff &&
                   ap_addr_ff == OFS_SERVICE;

   // Address phase capture; slave ready once out of reset, always OKAY
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ap_valid_ff <= 1'b0;
         ap_write_ff <= 1'b0;
         ap_addr_ff <= 8'h00;
         hreadyout_ff <= 1'b0;
         hresp_ff <= 1'b0;
      end else begin
         ap_valid_ff <= addr_take;
         ap_write_ff <= hwrite;
         ap_addr_ff <= {haddr[7:2], 2'h0};
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end
   end

   // Read mux, unmapped offsets read as zero
   always_comb begin
      nxt_rdata = 32'h00000000;
      unique case ({haddr[7:2], 2'h0})
         OFS_CTRL: nxt_rdata[CTRL_W-1:0] = ctrl_ff;
         OFS_STATUS: begin
            nxt_rdata[EVT_W-1:0] = status_ff;
            nxt_rdata[ST_RST_ACT] = rst_active;
            nxt_rdata[ST_UV_LVL] = uv_qual_ff;
         end
         OFS_MASK: nxt_rdata[EVT_W-1:0] = mask_ff;
         OFS_COUNT: nxt_rdata[CNT_W-1:0] = wd_cnt_ff;
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   // Read data registered at the address phase
   always_ff @(posedge clock) begin
      if (!nrst) begin
         hrdata_ff <= 32'h00000000;
      end else if (addr_take && !hwrite) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   // Control register
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= hwdata[CTRL_W-1:0];
      end
   end

   // Interrupt mask register
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mask_ff <= MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= hwdata[EVT_W-1:0];
      end
   end

   // Microsecond prescaler
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pre_ff <= '0;
         us_tick_ff <= 1'b0;
      end else if (pre_ff == PRE_W'(US_TICK_CYCLES - 1)) begin
         pre_ff <= '0;
         us_tick_ff <= 1'b1;
      end else begin
         pre_ff <= pre_ff + PRE_W'(1);
         us_tick_ff <= 1'b0;
      end
   end

   // Undervoltage filter: dips shorter than the delay are dropped
   always_ff @(posedge clock) begin
      if (!nrst) begin
         uv_us_ff <= 6'h00;
         uv_qual_ff <= 1'b0;
      end else if (!regulator_output_uv) begin
         uv_us_ff <= 6'h00;
         uv_qual_ff <= 1'b0;
      end else if (us_tick_ff && !uv_qual_ff) begin
         uv_us_ff <= uv_us_ff + 6'h01;
         uv_qual_ff <= (uv_us_ff + 6'h01) == UV_DLY_US;
      end
   end
   assign uv_evt = uv_qual_ff;

   // Service and limit checks; a service beats a same-cycle overflow
   assign svc_take = svc_wr && wd_en && !rst_active;
   assign early_evt = svc_take && win_check && wd_cnt_ff < early_lim;
   assign svc_ok = svc_take && !early_evt;
   assign ovf_evt = wd_en && !rst_active && !svc_wr &&
                    wd_cnt_ff >= late_lim;
   assign rst_trig = early_evt || ovf_evt || uv_evt;

   // Watchdog period counter in microseconds
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wd_cnt_ff <= '0;
      end else if (rst_active || rst_trig || svc_ok || wr_ctrl ||
                   !wd_en) begin
         wd_cnt_ff <= '0;
      end else if (us_tick_ff) begin
         wd_cnt_ff <= wd_cnt_ff + CNT_W'(1);
      end
   end

   // Reset pulse stretcher
   wdr_pulse u_pulse (
      .clock(clock),
      .nrst(nrst),
      .us_tick(us_tick_ff),
      .trigger(rst_trig),
      .len_sel(len_sel),
      .active(rst_active)
   );

   // Active-low reset output
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rst_out_n_ff <= 1'b1;
      end else begin
         rst_out_n_ff <= !rst_active;
      end
   end

   // Sticky status: event set wins over a write-one clear
   always_comb begin
      nxt_status = status_ff;
      if (wr_status) begin
         nxt_status = status_ff & ~hwdata[EVT_W-1:0];
      end
      if (early_evt) begin
         nxt_status[ST_EARLY] = 1'b1;
      end
      if (ovf_evt) begin
         nxt_status[ST_OVF] = 1'b1;
      end
      if (uv_evt) begin
         nxt_status[ST_UV] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         status_ff <= '0;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge clock) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_status & mask_ff);
      end
   end

   // Checks
   early_rst_a: assert property (
      @(posedge clock) disable iff (!nrst)
      early_evt |-> ##2 !system_reset_out_n)
      else $error("early service did not reset");

   early_gate_a: assert property (
      @(posedge clock) disable iff (!nrst)
      svc_wr && !win_check && !rst_active && !uv_evt |=> !rst_active)
      else $error("early reset outside normal window mode");

   window_ok_a: assert property (
      @(posedge clock) disable iff (!nrst)
      svc_ok && !uv_evt |=> wd_cnt_ff == '0 ##1 system_reset_out_n)
      else $error("in-window service did not restart cleanly");

   ovf_rst_a: assert property (
      @(posedge clock) disable iff (!nrst)
      ovf_evt |-> ##[1:2] !system_reset_out_n)
      else $error("overflow did not reset");

   late_bound_a: assert property (
      @(posedge clock) disable iff (!nrst)
      wd_en && !rst_active |-> wd_cnt_ff <= late_lim)
      else $error("period count ran past late limit");

   period_sel_a: assert property (
      @(posedge clock) disable iff (!nrst)
      ovf_evt |-> wd_cnt_ff == PERIOD_US[period_sel])
      else $error("overflow not at selected period");

   uv_filter_a: assert property (
      @(posedge clock) disable iff (!nrst)
      $rose(uv_qual_ff) |-> $past(regulator_output_uv) &&
                            $past(uv_us_ff) == UV_DLY_US - 6'h01)
      else $error("undervoltage qualified without full delay");

   uv_rst_a: assert property (
      @(posedge clock) disable iff (!nrst)
      uv_evt |-> ##[1:2] !system_reset_out_n)
      else $error("undervoltage did not drive reset low");

   restart_a: assert property (
      @(posedge clock) disable iff (!nrst)
      $fell(rst_active) |-> wd_cnt_ff == '0)
      else $error("period not restarted after reset pulse");

   sticky_a: assert property (
      @(posedge clock) disable iff (!nrst)
      ovf_evt |=> status_ff[ST_OVF])
      else $error("overflow flag not set");

   uv_delay_a: assert property (
      @(posedge clock) disable iff (!nrst)
      $rose(uv_qual_ff) |-> int'(uv_us_ff) >= UV_DLY_MIN_US &&
                            int'(uv_us_ff) <= UV_DLY_MAX_US)
      else $error("undervoltage delay outside allowed band");

   irq_level_a: assert property (
      @(posedge clock) disable iff (!nrst)
      1'b1 |=> irq == |(status_ff & $past(mask_ff)))
      else $error("interrupt level differs from unmasked status");

   flag_clear_a: assert property (
      @(posedge clock) disable iff (!nrst)
      wr_status && hwdata[ST_OVF] && !ovf_evt |=> !status_ff[ST_OVF])
      else $error("overflow flag not cleared by write of one");

   rst_hold_a: assert property (
      @(posedge clock) disable iff (!nrst)
      rst_active |=> !system_reset_out_n)
      else $error("reset output released during pulse");

   busy_svc_a: assert property (
      @(posedge clock) disable iff (!nrst)
      svc_wr && rst_active && !status_ff[ST_EARLY] |=>
         !status_ff[ST_EARLY])
      else $error("service during reset pulse was not ignored");

   early_c: cover property (@(posedge clock) disable iff (!nrst) early_evt);
   window_c: cover property (@(posedge clock) disable iff (!nrst) svc_ok);
   ovf_c: cover property (@(posedge clock) disable iff (!nrst) ovf_evt);
   uv_c: cover property (@(posedge clock) disable iff (!nrst) uv_evt);
   restart_c: cover property (@(posedge clock) disable iff (!nrst)
      $fell(rst_active));

endmodule

// *** dv/wdr_mcu.sv ***
`timescale 1ns/1ps
// Controller side of the reset line: counts and times reset pulses
module wdr_mcu (
   // Clock
   input wire logic clock,
   // Reset from the supervisor
   input wire logic system_reset_out_n,
   // Pulse record
   output int n_rst,
   output int width,
   output int cyc,
   output int fall_cyc
);
   int run;

   // Start from an empty record
   initial begin
      n_rst = 0;
      width = 0;
      cyc = 0;
      fall_cyc = 0;
      run = 0;
   end

   // Controller is held while the line is low, then restarts
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (system_reset_out_n === 1'b0) begin
         if (run == 0) begin
            n_rst <= n_rst + 1;
            fall_cyc <= cyc;
         end
         run <= run + 1;
      end else if (run != 0) begin
         width <= run;
         run <= 0;
      end
   end
endmodule

// *** dv/watchdog_reset_timing_tb_top.sv ***
`timescale 1ns/1ps
module watchdog_reset_timing_tb_top;
   import wdr_pkg::*;
   localparam int UT = 1;
   localparam int LIMIT = 95000;
   localparam int LO [4] = '{20000, 10000, 3600, 1000};
   localparam int HI [4] = '{25000, 12500, 5000, 1500};
   localparam logic [31:0] OV [2] = '{32'hC1, 32'hC6};
   logic clock, nrst, hsel, hwrite, hreadyout, hresp, uv, rst_n, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   int n_errors, num_checks, tcount, n0, c0;

   wdr_top #(.US_TICK_CYCLES(UT)) u_dut (
      .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .regulator_output_uv(uv),
      .system_reset_out_n(rst_n), .irq(irq));

   wdr_mcu u_mcu (
      .clock(clock), .system_reset_out_n(rst_n), .n_rst(),
      .width(), .cyc(), .fall_cyc());

   // Clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Closing report
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Range compare on bench measurements
   task automatic chkr(input int v, input int lo, input int hi);
      num_checks++;
      if (v < lo || v > hi) begin
         n_errors++;
         $display("BAD %0t %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask

   // One single AHB-Lite transfer, waiting on hready in both phases
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // Period count must be back near zero
   task automatic cnt0;
      bus(1'b0, OFS_COUNT, 32'h0);
      chk(32'(q < 32'd64), 32'h1);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Bounded wait for the reset line to reach a level
   task automatic wl(input logic lvl, input int lim);
      int i;
      i = 0;
      while (rst_n !== lvl && i < lim) begin
         @(posedge clock);
         i++;
      end
      if (i >= lim) begin
         n_errors++;
         $display("BAD %0t reset line stuck", $time);
      end
      @(posedge clock);
   endtask

   // Cut a hung run short
   always @(posedge clock) begin
      tcount++;
      if (tcount == LIMIT) begin
         n_errors++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      uv = 1'b0;
      n_errors = 0;
      num_checks = 0;
      tcount = 0;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      wt(2);
      // Reset values, write-only and unmapped places
      rd(OFS_CTRL, 32'h5);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_MASK, 32'h0);
      rd(OFS_SERVICE, 32'h0);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      chk(32'(hresp), 32'h0);
      // Early window service with every pulse length
      for (int l = 0; l < 4; l++) begin
         wr(OFS_CTRL, 32'(l * 64 + 6));
         wr(OFS_SERVICE, 32'h0);
         wl(1'b0, 10);
         wl(1'b1, 30000 * UT);
         chkr(u_mcu.width, LO[l] * UT, (HI[l] + 2) * UT);
         rd(OFS_STATUS, 32'h1);
         wr(OFS_STATUS, 32'h1);
         cnt0();
      end
      // In-window service restarts the period, twice running
      wr(OFS_CTRL, 32'h06);
      n0 = u_mcu.n_rst;
      repeat (2) begin
         wt(6000 * UT);
         wr(OFS_SERVICE, 32'h0);
         wt(4);
         cnt0();
      end
      chkr(u_mcu.n_rst, n0, n0);
      // Same moment is early for the doubled period
      wr(OFS_CTRL, 32'hCE);
      wt(6000 * UT);
      wr(OFS_SERVICE, 32'h0);
      wl(1'b0, 10);
      wl(1'b1, 3000 * UT);
      wr(OFS_STATUS, 32'h1);
      // Early service outside Normal window mode is harmless
      n0 = u_mcu.n_rst;
      wr(OFS_CTRL, 32'h07);
      wr(OFS_SERVICE, 32'h0);
      cnt0();
      wr(OFS_CTRL, 32'h02);
      wr(OFS_SERVICE, 32'h0);
      wr(OFS_CTRL, 32'h05);
      wr(OFS_SERVICE, 32'h0);
      wt(8);
      chkr(u_mcu.n_rst, n0, n0);
      rd(OFS_STATUS, 32'h0);
      // No service: Standby timeout, then Normal window
      for (int k = 0; k < 2; k++) begin
         wr(OFS_CTRL, OV[k]);
         c0 = u_mcu.cyc;
         wl(1'b0, 9000 * UT);
         chkr(u_mcu.fall_cyc - c0, 7200 * UT, 8880 * UT);
         wl(1'b1, 3000 * UT);
         rd(OFS_STATUS, 32'h2);
         wr(OFS_STATUS, 32'h2);
         cnt0();
      end
      // Undervoltage: short dip ignored, long one resets and interrupts
      wr(OFS_MASK, 32'h4);
      wr(OFS_CTRL, 32'hC0);
      n0 = u_mcu.n_rst;
      uv <= 1'b1;
      wt(5 * UT);
      uv <= 1'b0;
      wt(100 * UT);
      chkr(u_mcu.n_rst, n0, n0);
      rd(OFS_STATUS, 32'h0);
      uv <= 1'b1;
      c0 = u_mcu.cyc;
      wl(1'b0, 100 * UT);
      chkr(u_mcu.fall_cyc - c0, 6 * UT, 87 * UT);
      chk(32'(irq), 32'h1);
      rd(OFS_STATUS, 32'h1C);
      wr(OFS_CTRL, 32'hC6);
      wr(OFS_SERVICE, 32'h0);
      wr(OFS_MASK, 32'h0);
      wt(2);
      chk(32'(irq), 32'h0);
      wr(OFS_MASK, 32'h4);
      wt(2);
      chk(32'(irq), 32'h1);
      uv <= 1'b0;
      wl(1'b1, 3000 * UT);
      wr(OFS_STATUS, 32'h4);
      wt(2);
      chk(32'(irq), 32'h0);
      rd(OFS_STATUS, 32'h0);
      report_and_stop();
   end
endmodule
